// file: common/can_buf_pkg.sv
// Constants, field layouts and types for the CAN buffer status and transmit control block
package can_buf_pkg;

   // Register byte addresses
   localparam logic [7:0] ADDR_MASK_EID   = 8'h00;
   localparam logic [7:0] ADDR_FULL_LO    = 8'h04;
   localparam logic [7:0] ADDR_FULL_HI    = 8'h08;
   localparam logic [7:0] ADDR_OVF_LO     = 8'h0C;
   localparam logic [7:0] ADDR_OVF_HI     = 8'h10;
   localparam logic [7:0] ADDR_CTRL_BASE  = 8'h14;
   localparam logic [7:0] ADDR_CTRL_LAST  = 8'h20;

   // Reset values
   localparam logic [15:0] RST_MASK_EID   = 16'h0000;
   localparam logic [31:0] RST_FLAGS      = 32'h0000_0000;
   localparam logic [7:0]  RST_CTRL       = 8'h00;

   // Control byte layout
   localparam int CTRL_DIR   = 7;
   localparam int CTRL_ABT   = 6;
   localparam int CTRL_LARB  = 5;
   localparam int CTRL_ERR   = 4;
   localparam int CTRL_REQ   = 3;
   localparam int CTRL_RTREN = 2;
   localparam int CTRL_PRI_H = 1;
   localparam int CTRL_PRI_L = 0;
   localparam logic [7:0] CTRL_SW_MASK = 8'h8F;

   // Identifier word layout
   localparam int SID_LSB = 2;
   localparam int SID_MSB = 12;
   localparam int SRR_BIT = 1;
   localparam int IDE_BIT = 0;
   localparam int EID_MSB = 11;

   // Decoded register selector
   typedef enum logic [3:0] {
      SEL_MASK = 4'h0,
      SEL_FULL_LO = 4'h1,
      SEL_FULL_HI = 4'h2,
      SEL_OVF_LO = 4'h3,
      SEL_OVF_HI = 4'h4,
      SEL_CTRL = 4'h5,
      SEL_NONE = 4'hF
   } reg_sel_t;

   // Outcome reported by the protocol engine
   typedef enum logic [1:0] {
      TX_OK = 2'h0,
      TX_ABORTED = 2'h1,
      TX_LOST_ARB = 2'h2,
      TX_BUS_ERR = 2'h3
   } tx_result_t;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: design/can_buf_ctrl.sv
// CAN buffer status flags, pair control registers and AXI4-Lite register slave
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
module can_buf_ctrl
   import can_buf_pkg::*;
#(
   parameter int NUM_TX = 8
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // AXI4-Lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Receive events from protocol engine
   input  wire logic        rx_store_valid,
   input  wire logic [4:0]  rx_store_buf,
   input  wire logic        rx_remote_valid,
   input  wire logic [2:0]  rx_remote_buf,
   // Transmit outcome from protocol engine
   input  wire logic        tx_result_valid,
   input  wire logic [2:0]  tx_result_buf,
   input  wire logic [1:0]  tx_result_code,
   // Transmit selection to protocol engine
   output logic             tx_select_valid,
   output logic [2:0]       tx_select_buf,
   output logic [7:0]       tx_abort_request,
   output logic [7:0]       buffer_direction_select,
   // Identifier words for DMA RAM and filtering
   input  wire logic [10:0] frame_sid,
   input  wire logic        frame_srr,
   input  wire logic        frame_ide,
   input  wire logic [17:0] frame_eid,
   input  wire logic [15:0] filter_eid,
   output logic [15:0]      dma_sid_word,
   output logic [15:0]      dma_eid_word,
   output logic             ext_id_match,
   output logic [15:0]      mask_extended_id_low
);

   typedef struct packed {
      logic [15:0]      mask_eid;
      logic [31:0]      rx_full;
      logic [31:0]      rx_ovf;
      logic [7:0][7:0]  ctrl;
      logic [7:0]       abort_pending;
      logic             aw_held;
      logic [7:0]       aw_addr;
      logic             w_held;
      logic [15:0]      w_data;
      logic [1:0]       w_strb;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             rvalid;
      logic [1:0]       rresp;
      logic [15:0]      rdata;
      logic             sel_valid;
      logic [2:0]       sel_buf;
      logic [15:0]      sid_word;
      logic [15:0]      eid_word;
      logic             match;
   } state_t;

   state_t st;
   state_t next_st;

   logic [15:0] codec_sid;
   logic [15:0] codec_eid;
   logic        codec_match;

   // Map a byte address to a register selector
   function automatic reg_sel_t decode(input logic [7:0] addr);
      reg_sel_t sel;
      sel = SEL_NONE;
      if (addr[1:0] == 2'h0)
      begin
         if (addr == ADDR_MASK_EID)
            sel = SEL_MASK;
         else if (addr == ADDR_FULL_LO)
            sel = SEL_FULL_LO;
         else if (addr == ADDR_FULL_HI)
            sel = SEL_FULL_HI;
         else if (addr == ADDR_OVF_LO)
            sel = SEL_OVF_LO;
         else if (addr == ADDR_OVF_HI)
            sel = SEL_OVF_HI;
         else if (addr >= ADDR_CTRL_BASE && addr <= ADDR_CTRL_LAST)
            sel = SEL_CTRL;
      end
      return sel;
   endfunction

   // Pair index of a control register address
   function automatic logic [1:0] pair_of(input logic [7:0] addr);
      logic [7:0] diff;
      diff = addr - ADDR_CTRL_BASE;
      return diff[3:2];
   endfunction

   // Bits software clears: a bit written with zero in an enabled byte
   function automatic logic [15:0] clear_bits(input logic [15:0] data,
                                              input logic [1:0]  strb);
      logic [15:0] lanes;
      lanes = {{8{strb[1]}}, {8{strb[0]}}};
      return ~data & lanes;
   endfunction

   id_word_codec u_codec (
      .frame_sid  (frame_sid),
      .frame_srr  (frame_srr),
      .frame_ide  (frame_ide),
      .frame_eid  (frame_eid),
      .filter_eid (filter_eid),
      .mask_eid   (st.mask_eid),
      .sid_word   (codec_sid),
      .eid_word   (codec_eid),
      .eid_match  (codec_match)
   );

   always_comb
   begin
      logic        do_write;
      reg_sel_t    wsel;
      reg_sel_t    rsel;
      logic [1:0]  wpair;
      logic [1:0]  rpair;
      logic [15:0] clr;
      logic [31:0] full_clr;
      logic [31:0] ovf_clr;
      logic [31:0] full_set;
      logic [31:0] ovf_set;
      logic [7:0]  old_b;
      logic [7:0]  wb;
      logic [1:0]  best_pri;
      logic [3:0]  idx;
      next_st = st;
      do_write = 1'b0;
      wsel = SEL_NONE;
      rsel = SEL_NONE;
      wpair = 2'h0;
      rpair = 2'h0;
      clr = 16'h0000;
      full_clr = 32'h0000_0000;
      ovf_clr = 32'h0000_0000;
      full_set = 32'h0000_0000;
      ovf_set = 32'h0000_0000;
      old_b = 8'h00;
      wb = 8'h00;
      best_pri = 2'h0;
      idx = 4'h0;

      // Address and data accepted in either order
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_st.w_held = 1'b1;
         next_st.w_data = s_axi_wdata[15:0];
         next_st.w_strb = s_axi_wstrb[1:0];
      end
      if (st.bvalid && s_axi_bready)
         next_st.bvalid = 1'b0;

      if (st.aw_held && st.w_held)
      begin
         do_write = 1'b1;
         wsel = decode(st.aw_addr);
         wpair = pair_of(st.aw_addr);
         clr = clear_bits(st.w_data, st.w_strb);
         next_st.aw_held = 1'b0;
         next_st.w_held = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end

      // Software clears on flag registers; writing one keeps the flag
      if (do_write)
      begin
         unique case (wsel)
            SEL_MASK:
            begin
               if (st.w_strb[0])
                  next_st.mask_eid[7:0] = st.w_data[7:0];
               if (st.w_strb[1])
                  next_st.mask_eid[15:8] = st.w_data[15:8];
            end
            SEL_FULL_LO:
               full_clr[15:0] = clr;
            SEL_FULL_HI:
               full_clr[31:16] = clr;
            SEL_OVF_LO:
               ovf_clr[15:0] = clr;
            SEL_OVF_HI:
               ovf_clr[31:16] = clr;
            SEL_CTRL:
            begin
               // low lane even buffer, high lane odd buffer
               for (int lane = 0; lane < 2; lane++)
               begin
                  if (st.w_strb[lane])
                  begin
                     idx = {1'b0, wpair, 1'b0} + 4'(lane);
                     old_b = st.ctrl[idx[2:0]];
                     wb = st.w_data[lane*8 +: 8];
                     next_st.ctrl[idx[2:0]] = (old_b & ~CTRL_SW_MASK) | (wb & CTRL_SW_MASK);
                     // zero over a set request means abort
                     if (old_b[CTRL_REQ] && !wb[CTRL_REQ])
                        next_st.abort_pending[idx[2:0]] = 1'b1;
                     if (!old_b[CTRL_REQ] && wb[CTRL_REQ])
                     begin
                        next_st.ctrl[idx[2:0]][CTRL_ABT] = 1'b0;
                        next_st.ctrl[idx[2:0]][CTRL_LARB] = 1'b0;
                        next_st.ctrl[idx[2:0]][CTRL_ERR] = 1'b0;
                        next_st.abort_pending[idx[2:0]] = 1'b0;
                     end
                  end
               end
            end
            SEL_NONE:
            begin
            end
            default:
            begin
            end
         endcase
      end

      // store into a full buffer overflows it
      if (rx_store_valid)
      begin
         if (st.rx_full[rx_store_buf])
            ovf_set[rx_store_buf] = 1'b1;
         else
            full_set[rx_store_buf] = 1'b1;
      end
      // one bit per buffer across two halves
      // hardware set wins over software clear
      next_st.rx_full = (st.rx_full & ~full_clr) | full_set;
      // overflow only ever cleared by software
      next_st.rx_ovf = (st.rx_ovf & ~ovf_clr) | ovf_set;

      // remote frame raises request only when enabled
      if (rx_remote_valid && st.ctrl[rx_remote_buf][CTRL_RTREN]
          && !next_st.ctrl[rx_remote_buf][CTRL_REQ])
      begin
         next_st.ctrl[rx_remote_buf][CTRL_REQ] = 1'b1;
         // flags cleared with the new request
         next_st.ctrl[rx_remote_buf][CTRL_ABT] = 1'b0;
         next_st.ctrl[rx_remote_buf][CTRL_LARB] = 1'b0;
         next_st.ctrl[rx_remote_buf][CTRL_ERR] = 1'b0;
      end

      // Engine outcome; a retry keeps the request standing
      if (tx_result_valid)
      begin
         unique case (tx_result_t'(tx_result_code))
            TX_OK:
            begin
               next_st.ctrl[tx_result_buf][CTRL_REQ] = 1'b0;
               next_st.ctrl[tx_result_buf][CTRL_ABT] = 1'b0;
               next_st.abort_pending[tx_result_buf] = 1'b0;
            end
            TX_ABORTED:
            begin
               next_st.ctrl[tx_result_buf][CTRL_ABT] = 1'b1;
               next_st.abort_pending[tx_result_buf] = 1'b0;
            end
            TX_LOST_ARB:
               next_st.ctrl[tx_result_buf][CTRL_LARB] = 1'b1;
            TX_BUS_ERR:
               next_st.ctrl[tx_result_buf][CTRL_ERR] = 1'b1;
         endcase
      end

      // highest priority pending wins, lowest index on a tie
      next_st.sel_valid = 1'b0;
      next_st.sel_buf = 3'h0;
      for (int b = 0; b < NUM_TX; b++)
      begin
         if (st.ctrl[b][CTRL_DIR] && st.ctrl[b][CTRL_REQ] && !st.abort_pending[b])
         begin
            if (!next_st.sel_valid || st.ctrl[b][CTRL_PRI_H:CTRL_PRI_L] > best_pri)
            begin
               next_st.sel_valid = 1'b1;
               next_st.sel_buf = 3'(b);
               best_pri = st.ctrl[b][CTRL_PRI_H:CTRL_PRI_L];
            end
         end
      end

      // Read channel; one read outstanding at a time
      if (st.rvalid && s_axi_rready)
         next_st.rvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         rsel = decode(s_axi_araddr);
         rpair = pair_of(s_axi_araddr);
         next_st.rvalid = 1'b1;
         next_st.rresp = RESP_OKAY;
         unique case (rsel)
            SEL_MASK:
               next_st.rdata = st.mask_eid;
            SEL_FULL_LO:
               next_st.rdata = st.rx_full[15:0];
            SEL_FULL_HI:
               next_st.rdata = st.rx_full[31:16];
            SEL_OVF_LO:
               next_st.rdata = st.rx_ovf[15:0];
            SEL_OVF_HI:
               next_st.rdata = st.rx_ovf[31:16];
            SEL_CTRL:
               next_st.rdata = {st.ctrl[{rpair, 1'b1}], st.ctrl[{rpair, 1'b0}]};
            SEL_NONE:
            begin
               next_st.rdata = 16'h0000;
               next_st.rresp = RESP_SLVERR;
            end
            default:
            begin
               next_st.rdata = 16'h0000;
               next_st.rresp = RESP_SLVERR;
            end
         endcase
      end

      // identifier words leave as DMA RAM data, never mapped here
      next_st.sid_word = codec_sid;
      next_st.eid_word = codec_eid;
      next_st.match = codec_match;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st <= '0;
         st.mask_eid <= RST_MASK_EID;
         st.rx_full <= RST_FLAGS;
         st.rx_ovf <= RST_FLAGS;
         st.ctrl <= {8{RST_CTRL}};
      end
      else
         st <= next_st;
   end

   // Holding a response blocks new writes, so one write is in flight
   assign s_axi_awready = !st.aw_held && !st.bvalid;
   assign s_axi_wready = !st.w_held && !st.bvalid;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = !st.rvalid;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rresp = st.rresp;
   assign s_axi_rdata = {16'h0000, st.rdata};

   assign tx_select_valid = st.sel_valid;
   assign tx_select_buf = st.sel_buf;
   assign tx_abort_request = st.abort_pending;
   always_comb
   begin
      for (int b = 0; b < 8; b++)
         buffer_direction_select[b] = st.ctrl[b][CTRL_DIR];
   end

   assign dma_sid_word = st.sid_word;
   assign dma_eid_word = st.eid_word;
   assign ext_id_match = st.match;
   assign mask_extended_id_low = st.mask_eid;

endmodule

// file: design/id_word_codec.sv
// Packing of DMA RAM identifier words and masked extended-id comparison
module id_word_codec
   import can_buf_pkg::*;
(
   // Frame identifier fields
   input  wire logic [10:0] frame_sid,
   input  wire logic        frame_srr,
   input  wire logic        frame_ide,
   input  wire logic [17:0] frame_eid,
   // Filter comparison
   input  wire logic [15:0] filter_eid,
   input  wire logic [15:0] mask_eid,
   // Results
   output logic      [15:0] sid_word,
   output logic      [15:0] eid_word,
   output logic             eid_match
);

   always_comb
   begin
      sid_word = 16'h0000;
      eid_word = 16'h0000;
      // identifier field, unused top bits zero
      sid_word[SID_MSB:SID_LSB] = frame_sid;
      sid_word[SRR_BIT] = frame_srr;
      sid_word[IDE_BIT] = frame_ide;
      eid_word[EID_MSB:0] = frame_eid[17:6];
      // masked compare on low identifier bits
      eid_match = ((frame_eid[15:0] ^ filter_eid) & mask_eid) == 16'h0000;
   end

endmodule

// file: testbench/can_buf_ctrl_chk.sv
// Port assertions for the CAN buffer control block
module can_buf_ctrl_chk
   import can_buf_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   // Engine events and abort
   input wire logic        tx_result_valid,
   input wire logic [2:0]  tx_result_buf,
   input wire logic [1:0]  tx_result_code,
   input wire logic [7:0]  tx_abort_request,
   input wire logic        rx_store_valid,
   // Identifier path
   input wire logic [10:0] frame_sid,
   input wire logic        frame_srr,
   input wire logic        frame_ide,
   input wire logic [17:0] frame_eid,
   input wire logic [15:0] filter_eid,
   input wire logic [15:0] dma_sid_word,
   input wire logic [15:0] dma_eid_word,
   input wire logic        ext_id_match,
   input wire logic [15:0] mask_extended_id_low
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic [11:0] eid_top = frame_eid[17:6];
   wire logic [15:0] eid_cmp = (frame_eid[15:0] ^ filter_eid) & mask_extended_id_low;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Words lag inputs one cycle, so the edge after reset is skipped
   AST_SID_FIELD: assert property ($past(rstn) |-> dma_sid_word[12:2] == $past(frame_sid))
      else $error("sid field wrong");
   AST_SID_TOP: assert property (dma_sid_word[15:13] == 3'h0)
      else $error("sid top bits set");
   AST_SRR: assert property ($past(rstn) |-> dma_sid_word[1] == $past(frame_srr))
      else $error("srr bit wrong");
   AST_IDE: assert property ($past(rstn) |-> dma_sid_word[0] == $past(frame_ide))
      else $error("ide bit wrong");
   AST_EID_FIELD: assert property ($past(rstn) |-> dma_eid_word[11:0] == $past(eid_top))
      else $error("eid field wrong");
   AST_EID_TOP: assert property (dma_eid_word[15:12] == 4'h0)
      else $error("eid top bits set");
   AST_MASK_CMP: assert property ($past(rstn) |-> ext_id_match == ($past(eid_cmp) == 16'h0))
      else $error("masked match wrong");
   AST_ABORT_END: assert property (tx_result_valid && tx_result_code == TX_ABORTED
      |=> !tx_abort_request[$past(tx_result_buf)]) else $error("abort request kept");
   cover property (rx_store_valid);
   cover property (tx_result_valid && tx_result_code == TX_ABORTED);
   cover property (ext_id_match && mask_extended_id_low != 16'h0);
endmodule
bind can_buf_ctrl can_buf_ctrl_chk i_chk (
   .clk, .rstn, .tx_result_valid, .tx_result_buf, .tx_result_code, .tx_abort_request,
   .rx_store_valid, .frame_sid, .frame_srr, .frame_ide, .frame_eid, .filter_eid,
   .dma_sid_word, .dma_eid_word, .ext_id_match, .mask_extended_id_low
);

// file: testbench/can_engine_model.sv
// Behavioural CAN protocol engine producing buffer events
module can_engine_model
   import can_buf_pkg::*;
(
   // Clock
   input  wire logic  clk,
   // Receive events
   output logic       rx_store_valid,
   output logic [4:0] rx_store_buf,
   output logic       rx_remote_valid,
   output logic [2:0] rx_remote_buf,
   // Transmit outcome
   output logic       tx_result_valid,
   output logic [2:0] tx_result_buf,
   output logic [1:0] tx_result_code
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      {rx_store_valid, rx_remote_valid, tx_result_valid} = 3'h0;
      {rx_store_buf, rx_remote_buf, tx_result_buf, tx_result_code} = 13'h0;
   end
   task automatic store(input logic [4:0] n);
      @(posedge clk);
      rx_store_valid <= 1'b1;
      rx_store_buf   <= n;
      @(posedge clk);
      rx_store_valid <= 1'b0;
      // Index is junk between events
      rx_store_buf   <= ~n;
   endtask
   task automatic remote(input logic [2:0] n);
      @(posedge clk);
      rx_remote_valid <= 1'b1;
      rx_remote_buf   <= n;
      @(posedge clk);
      rx_remote_valid <= 1'b0;
      rx_remote_buf   <= ~n;
   endtask
   task automatic result(input logic [2:0] n, input logic [1:0] c);
      @(posedge clk);
      tx_result_valid <= 1'b1;
      tx_result_buf   <= n;
      tx_result_code  <= c;
      @(posedge clk);
      tx_result_valid <= 1'b0;
      tx_result_buf   <= ~n;
      tx_result_code  <= ~c;
   endtask
endmodule

// file: testbench/tb_can_buffer_status_and_tx_control.sv
// Self-checking bench for the CAN buffer status and transmit control block
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
   $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_can_buffer_status_and_tx_control
   import can_buf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, rx_store_valid, rx_remote_valid, tx_result_valid;
   logic        tx_select_valid, frame_srr, frame_ide, ext_id_match;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, tx_abort_request, buffer_direction_select;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_d, x, y;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, tx_result_code, rd_r;
   logic [4:0]  rx_store_buf;
   logic [2:0]  rx_remote_buf, tx_result_buf, tx_select_buf;
   logic [10:0] frame_sid;
   logic [17:0] frame_eid;
   logic [15:0] filter_eid, dma_sid_word, dma_eid_word, mask_extended_id_low, m;
   logic [4:0]  bl [5];
   int          mismatches, checks, cycles;

   can_buf_ctrl #(.NUM_TX(8)) i_dut (
      .clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .rx_store_valid, .rx_store_buf, .rx_remote_valid,
      .rx_remote_buf, .tx_result_valid, .tx_result_buf, .tx_result_code, .tx_select_valid,
      .tx_select_buf, .tx_abort_request, .buffer_direction_select, .frame_sid, .frame_srr,
      .frame_ide, .frame_eid, .filter_eid, .dma_sid_word, .dma_eid_word, .ext_id_match,
      .mask_extended_id_low
   );
   can_engine_model i_eng (
      .clk, .rx_store_valid, .rx_store_buf, .rx_remote_valid, .rx_remote_buf,
      .tx_result_valid, .tx_result_buf, .tx_result_code
   );

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Ceiling well above the expected run length
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         wrap_up();
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      logic [1:0] rb;
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         // Sample just before the edge that takes the item
         @(negedge clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         rb = s_axi_bresp;
         @(posedge clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end while (!tb);
      s_axi_bready <= 1'b0;
      `CHK("bresp", RESP_OKAY, rb)
   endtask

   task automatic rd(input logic [7:0] a);
      logic t, tr;
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(negedge clk);
         t = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         rd_d = s_axi_rdata;
         rd_r = s_axi_rresp;
         @(posedge clk);
         if (t) s_axi_arvalid <= 1'b0;
      end while (!tr);
      s_axi_rready <= 1'b0;
   endtask

   // Low register then high register, as one 32-buffer word
   task automatic flags(input logic [7:0] a, input logic [31:0] e, input string nm);
      logic [31:0] v;
      rd(a);
      v[15:0] = rd_d[15:0];
      rd(a + 8'h04);
      v[31:16] = rd_d[15:0];
      `CHK(nm, e, v)
   endtask

   task automatic clr(input logic [7:0] a, input logic [31:0] d);
      wr(a, d);
      wr(a + 8'h04, d);
   endtask

   task automatic ctl(input logic [7:0] a, input logic [15:0] e, input string nm);
      rd(a);
      `CHK(nm, {16'h0, e}, rd_d)
   endtask

   function automatic logic [15:0] e_sid(logic [31:0] v);
      return {3'h0, v[10:0], v[11], v[12]};
   endfunction

   function automatic logic e_match(logic [17:0] e, logic [15:0] f, logic [15:0] k);
      return ((e[15:0] ^ f) & k) == 16'h0;
   endfunction

   initial
   begin
      {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, frame_sid, frame_srr, frame_ide} = '0;
      {frame_eid, filter_eid} = '0;
      s_axi_wstrb = 4'h3;
      void'($urandom(2));
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      for (int a = 0; a <= 32; a += 4)
      begin
         rd(a[7:0]);
         `CHK("reset", 32'h0, rd_d)
      end
      rd(8'h24);
      `CHK("unmapped", RESP_SLVERR, rd_r)
      m = $urandom;
      wr(ADDR_MASK_EID, {16'h0, m});
      ctl(ADDR_MASK_EID, m, "mask");
      `CHK("mask_out", m, mask_extended_id_low)
      // High lane only: low byte of the mask must survive
      s_axi_wstrb <= 4'h2;
      wr(ADDR_MASK_EID, 32'h0);
      s_axi_wstrb <= 4'h3;
      m[15:8] = 8'h00;
      ctl(ADDR_MASK_EID, m, "mask_lane");
      repeat (40)
      begin
         x = $urandom;
         y = $urandom;
         @(posedge clk);
         {frame_sid, frame_srr, frame_ide} <= {x[10:0], x[11], x[12]};
         frame_eid <= y[17:0];
         filter_eid <= x[13] ? (y[15:0] ^ (x[31:16] & ~m)) : y[31:16];
         @(posedge clk);
         @(negedge clk);
         `CHK("sid", e_sid(x), dma_sid_word)
         `CHK("eid", {4'h0, y[17:6]}, dma_eid_word)
         `CHK("match", e_match(y[17:0], filter_eid, m), ext_id_match)
      end
      bl = '{5'd0, 5'd15, 5'd16, 5'd31, 5'($urandom_range(31))};
      foreach (bl[k])
      begin
         i_eng.store(bl[k]);
         flags(ADDR_FULL_LO, 32'h1 << bl[k], "full");
         clr(ADDR_FULL_LO, 32'hFFFF);
         flags(ADDR_FULL_LO, 32'h1 << bl[k], "full_w1");
         i_eng.store(bl[k]);
         flags(ADDR_OVF_LO, 32'h1 << bl[k], "ovf");
         clr(ADDR_FULL_LO, 32'h0);
         flags(ADDR_FULL_LO, 32'h0, "full_clr");
         flags(ADDR_OVF_LO, 32'h1 << bl[k], "ovf_kept");
         clr(ADDR_OVF_LO, 32'h0);
         flags(ADDR_OVF_LO, 32'h0, "ovf_clr");
         // Store lands on the edge that performs the clear
         fork
            wr(ADDR_FULL_LO + (bl[k][4] ? 8'h04 : 8'h00), 32'h0);
            begin
               @(posedge clk);
               i_eng.store(bl[k]);
            end
         join
         flags(ADDR_FULL_LO, 32'h1 << bl[k], "full_set_wins");
         clr(ADDR_FULL_LO, 32'h0);
      end
      wr(ADDR_CTRL_BASE, 32'h898B);
      ctl(ADDR_CTRL_BASE, 16'h898B, "pair");
      repeat (2) @(negedge clk);
      `CHK("dir", 8'h03, buffer_direction_select)
      `CHK("sel_hi", 4'h8, {tx_select_valid, tx_select_buf})
      i_eng.result(3'd0, TX_OK);
      ctl(ADDR_CTRL_BASE, 16'h8983, "sent");
      i_eng.result(3'd1, TX_LOST_ARB);
      ctl(ADDR_CTRL_BASE, 16'hA983, "lost");
      wr(ADDR_CTRL_BASE, 32'h8183);
      repeat (2) @(negedge clk);
      `CHK("abort_req", 8'h02, tx_abort_request)
      i_eng.result(3'd1, TX_ABORTED);
      rd(ADDR_CTRL_BASE);
      `CHK("aborted", 1'b1, rd_d[14])
      wr(ADDR_CTRL_BASE, 32'h8983);
      ctl(ADDR_CTRL_BASE, 16'h8983, "rereq");
      i_eng.result(3'd1, TX_BUS_ERR);
      ctl(ADDR_CTRL_BASE, 16'h9983, "buserr");
      wr(ADDR_CTRL_BASE + 8'h04, 32'h8084);
      i_eng.remote(3'd2);
      i_eng.remote(3'd3);
      ctl(ADDR_CTRL_BASE + 8'h04, 16'h808C, "remote");
      repeat (2) @(negedge clk);
      `CHK("sel_lo", 4'h9, {tx_select_valid, tx_select_buf})
      wrap_up();
   end
endmodule
